// >>> hc_buffer_ram_defines.vh
// Command codes, field positions, reset values for buffer RAM control
`ifndef HC_BUFFER_RAM_DEFINES_VH
`define HC_BUFFER_RAM_DEFINES_VH
`define CMD_STATUS_RD      8'h2C
`define CMD_STATUS_WR      8'hAC
`define CMD_WINDOW_RD      8'h32
`define CMD_WINDOW_WR      8'hB2
`define CMD_PORT_RD        8'h45
`define CMD_PORT_WR        8'hC5
`define CMD_SOFT_RESET_WR  8'hA9
`define SOFT_RESET_KEY     16'h00F6
`define BIT_HALF_FLAG      10
`define BIT_ISO_B_DONE     9
`define BIT_ISO_A_DONE     8
`define BIT_ISO_B_IN_USE   6
`define BIT_ISO_A_IN_USE   5
`define BIT_CLEAR_HALF     4
`define BIT_ASYNC_EN       3
`define BIT_PERIODIC_EN    2
`define BIT_ISO_B_EN       1
`define BIT_ISO_A_EN       0
`define CTRL_RESET         5'h00
`define WINDOW_RESET       32'h0000_0000
`define PORT_RESET         16'h0000
`define WINDOW_WR_MASK     32'hFFFF_7FFF
`endif

// >>> word_stepper.v
// Direct-access pointer and remaining-count stepper for the data port
`timescale 1ns/1ps
`default_nettype none
module word_stepper #(
  parameter AW = 15,
  parameter CW = 16
)(
  input  wire          clk_i,    // Clock
  input  wire          rst_i,    // Synchronous reset, high
  input  wire          load_i,   // Load new start and count
  input  wire [AW-1:0] start_i,  // Start address
  input  wire [CW-1:0] count_i,  // Byte count
  input  wire          step_i,   // One 16-bit word transferred
  output reg  [AW-1:0] addr_o,   // Current byte address
  output reg  [CW-1:0] left_o,   // Bytes remaining
  output reg           done_o    // Count exhausted
);
  // An odd final byte still consumes a whole word access
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_o <= {AW{1'b0}};
      left_o <= {CW{1'b0}};
      done_o <= 1'b1;
    end
    else if (load_i)
    begin
      addr_o <= start_i;
      left_o <= count_i;
      done_o <= (count_i == {CW{1'b0}});
    end
    else if (step_i && !done_o)
    begin
      addr_o <= addr_o + {{(AW-2){1'b0}}, 2'b10};
      if (left_o <= {{(CW-2){1'b0}}, 2'b10})
      begin
        left_o <= {CW{1'b0}};
        done_o <= 1'b1;
      end
      else
        left_o <= left_o - {{(CW-2){1'b0}}, 2'b10};
    end
  end
endmodule // word_stepper
`default_nettype wire

// >>> hc_buffer_ram_control.v
// Host-controller buffer RAM status/control and direct-access data port
// Function
// - Status/control register read with code 2Ch, written with code ACh.
// - Bit 10 reports active half of paired descriptor: 0 ping, 1 pong.
// - Bit 9 reads 1 once second iso list buffer was read.
// - Bit 8 reads 1 once first iso list buffer was read.
// - Bits 6 and 5 show second and first iso buffers in use.
// - Bit 4 rising clears half flag only while async enable is 0.
// - Bit 3 enables async transfer list processing.
// - Bit 2 enables periodic transfer list processing.
// - Bit 1 enables second iso list processing.
// - Bit 0 enables first iso list processing.
// - 32-bit window register read with code 32h, written with B2h.
// - Window bits 31..16 hold byte total; read/write, reset zero.
// - Window bits 14..0 hold start pointer; bit 15 reserved.
// - 16-bit data port read with code 45h, written with C5h.
// - Writing F6h to soft reset register resets registers, not memory.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "hc_buffer_ram_defines.vh"
module hc_buffer_ram_control #(
  parameter AW = 15,
  parameter CW = 16
)(
  input  wire          clk_i,           // Clock, 125 MHz
  input  wire          rst_i,           // Synchronous reset, high
  input  wire [7:0]    addr_i,          // Command code
  input  wire [31:0]   wdata_i,         // Write data
  input  wire          wr_i,            // Write strobe
  input  wire          rd_i,            // Read strobe
  output reg  [31:0]   rdata_o,         // Read data, cycle after read
  input  wire          half_toggle_i,   // Engine toggles paired-descriptor half
  input  wire          iso_a_read_i,    // Engine finished reading first iso buffer
  input  wire          iso_b_read_i,    // Engine finished reading second iso buffer
  input  wire          iso_a_refill_i,  // First iso buffer refilled, clears done
  input  wire          iso_b_refill_i,  // Second iso buffer refilled, clears done
  input  wire          iso_a_busy_i,    // First iso buffer accessed by engine
  input  wire          iso_b_busy_i,    // Second iso buffer accessed by engine
  output reg           async_en_o,      // Process async transfer list
  output reg           periodic_en_o,   // Process periodic transfer list
  output reg           iso_a_en_o,      // Process first iso list
  output reg           iso_b_en_o,      // Process second iso list
  output reg           mem_wr_o,        // Buffer memory write
  output reg           mem_rd_o,        // Buffer memory read request
  output reg  [AW-1:0] mem_addr_o,      // Buffer memory byte address
  output reg  [15:0]   mem_wdata_o,     // Buffer memory write word
  input  wire [15:0]   mem_rdata_i,     // Buffer memory read word, same cycle
  output reg           port_done_o      // Byte total reached
);

  reg          clear_half_flag;
  reg          paired_desc_half_flag;
  reg          iso_list_a_read_done;
  reg          iso_list_b_read_done;
  reg          iso_list_a_in_use;
  reg          iso_list_b_in_use;
  reg [31:0]   direct_access_window;
  reg [15:0]   port_word;
  wire [AW-1:0] cur_addr;
  wire [CW-1:0] bytes_left;
  wire          win_done;
  wire          soft_rst;
  wire          any_rst;
  wire          port_wr;
  wire          port_rd;
  wire          win_wr;
  wire          stat_wr;

  function hit;
    input [7:0] code;
    input [7:0] want;
    begin
      hit = (code == want);
    end
  endfunction

  // Soft reset leaves buffer memory untouched; only registers clear
  assign soft_rst = wr_i && hit(addr_i, `CMD_SOFT_RESET_WR) &&
                    (wdata_i[15:0] == `SOFT_RESET_KEY);
  assign any_rst  = rst_i || soft_rst;
  assign stat_wr  = wr_i && hit(addr_i, `CMD_STATUS_WR);
  assign win_wr   = wr_i && hit(addr_i, `CMD_WINDOW_WR);
  // Port traffic relies on the window having been set first
  assign port_wr  = wr_i && hit(addr_i, `CMD_PORT_WR) && !win_done;
  assign port_rd  = rd_i && hit(addr_i, `CMD_PORT_RD) && !win_done;

  word_stepper #(
    .AW (AW),
    .CW (CW)
  ) u_stepper (
    .clk_i   (clk_i),
    .rst_i   (any_rst),
    .load_i  (win_wr),
    .start_i (wdata_i[AW-1:0]),
    .count_i (wdata_i[16+CW-1:16]),
    .step_i  (port_wr || port_rd),
    .addr_o  (cur_addr),
    .left_o  (bytes_left),
    .done_o  (win_done)
  );

  always @(posedge clk_i)
  begin
    if (any_rst)
    begin
      {async_en_o, periodic_en_o, iso_b_en_o, iso_a_en_o} <= 4'h0;
      clear_half_flag      <= 1'b0;
      direct_access_window <= `WINDOW_RESET;
    end
    else
    begin
      if (stat_wr)
      begin
        async_en_o      <= wdata_i[`BIT_ASYNC_EN];
        periodic_en_o   <= wdata_i[`BIT_PERIODIC_EN];
        iso_b_en_o      <= wdata_i[`BIT_ISO_B_EN];
        iso_a_en_o      <= wdata_i[`BIT_ISO_A_EN];
        clear_half_flag <= wdata_i[`BIT_CLEAR_HALF];
      end
      if (win_wr)
        direct_access_window <= wdata_i & `WINDOW_WR_MASK;
    end
  end

  // Hardware events win over a concurrent clear
  always @(posedge clk_i)
  begin
    if (any_rst)
    begin
      paired_desc_half_flag <= 1'b0;
      iso_list_a_read_done  <= 1'b0;
      iso_list_b_read_done  <= 1'b0;
      iso_list_a_in_use     <= 1'b0;
      iso_list_b_in_use     <= 1'b0;
    end
    else
    begin
      if (half_toggle_i && async_en_o)
        paired_desc_half_flag <= ~paired_desc_half_flag;
      else if (stat_wr && wdata_i[`BIT_CLEAR_HALF] && !clear_half_flag && !async_en_o)
        paired_desc_half_flag <= 1'b0;
      if (iso_a_read_i)
        iso_list_a_read_done <= 1'b1;
      else if (iso_a_refill_i)
        iso_list_a_read_done <= 1'b0;
      if (iso_b_read_i)
        iso_list_b_read_done <= 1'b1;
      else if (iso_b_refill_i)
        iso_list_b_read_done <= 1'b0;
      iso_list_a_in_use <= iso_a_busy_i;
      iso_list_b_in_use <= iso_b_busy_i;
    end
  end

  always @(posedge clk_i)
  begin
    if (any_rst)
    begin
      port_word   <= `PORT_RESET;
      mem_wr_o    <= 1'b0;
      mem_rd_o    <= 1'b0;
      mem_addr_o  <= {AW{1'b0}};
      mem_wdata_o <= 16'h0000;
      port_done_o <= 1'b1;
    end
    else
    begin
      mem_wr_o    <= port_wr;
      mem_rd_o    <= port_rd;
      // Follows the stepper's flag on the same edge, so the pin never lags a window load
      if (win_wr)
        port_done_o <= (wdata_i[16+CW-1:16] == {CW{1'b0}});
      else if ((port_wr || port_rd) && (bytes_left <= {{(CW-2){1'b0}}, 2'b10}))
        port_done_o <= 1'b1;
      if (port_wr || port_rd)
        mem_addr_o <= cur_addr;
      if (port_wr)
      begin
        mem_wdata_o <= wdata_i[15:0];
        port_word   <= wdata_i[15:0];
      end
      else if (port_rd)
        port_word <= mem_rdata_i;
    end
  end

  always @(posedge clk_i)
  begin
    if (any_rst)
      rdata_o <= 32'h0000_0000;
    else if (rd_i)
    begin
      case (addr_i)
        `CMD_STATUS_RD: rdata_o <= {21'h0_0000, paired_desc_half_flag, iso_list_b_read_done,
                                    iso_list_a_read_done, 1'b0, iso_list_b_in_use, iso_list_a_in_use,
                                    clear_half_flag, async_en_o, periodic_en_o,
                                    iso_b_en_o, iso_a_en_o};
        `CMD_WINDOW_RD: rdata_o <= direct_access_window;
        `CMD_PORT_RD:   rdata_o <= {16'h0000, (win_done ? port_word : mem_rdata_i)};
        default:        rdata_o <= 32'h0000_0000;
      endcase
    end
    else
      rdata_o <= 32'h0000_0000;
  end

endmodule // hc_buffer_ram_control
`default_nettype wire

// >>> hc_buffer_ram_control_sva.sv
// Port assertions for the buffer RAM control block
`timescale 1ns/1ps
`default_nettype none
module hc_buffer_ram_control_sva #(
  parameter AW = 15
)(
  input wire logic          clk_i,         // clock
  input wire logic          rst_i,         // reset
  input wire logic [7:0]    addr_i,        // code
  input wire logic [31:0]   wdata_i,       // write data
  input wire logic          wr_i,          // write
  input wire logic          rd_i,          // read
  input wire logic [31:0]   rdata_o,       // read data
  input wire logic          async_en_o,    // enable
  input wire logic          periodic_en_o, // enable
  input wire logic          iso_a_en_o,    // enable
  input wire logic          iso_b_en_o,    // enable
  input wire logic          mem_wr_o,      // mem write
  input wire logic          mem_rd_o,      // mem read
  input wire logic [AW-1:0] mem_addr_o,    // mem address
  input wire logic          port_done_o    // total reached
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic [3:0] en = {async_en_o, periodic_en_o, iso_b_en_o, iso_a_en_o};
  wire logic       port_go = !port_done_o && (rd_i && addr_i == 8'h45 || wr_i && addr_i == 8'hC5);
  a_status_write: assert property (wr_i && addr_i == 8'hAC |=> en == $past(wdata_i[3:0]))
    else $error("enables differ from status write");
  // A soft reset clears the enables on the edge after its write; the edge after that is excluded as well
  a_enables_hold: assert property (!(wr_i && addr_i inside {8'hAC, 8'hA9}) && !$past(wr_i && addr_i == 8'hA9)
    |=> $stable(en))
    else $error("enables moved without a write");
  a_read_zero: assert property (!(rd_i && addr_i inside {8'h2C, 8'h32, 8'h45}) |=> rdata_o == 0)
    else $error("read data not zero");
  a_port_fetch: assert property (rd_i && addr_i == 8'h45 && !port_done_o |=> mem_rd_o && !mem_wr_o)
    else $error("port read did not fetch");
  a_port_refused: assert property (port_done_o && (rd_i && addr_i == 8'h45 || wr_i && addr_i == 8'hC5)
    |=> !mem_rd_o && !mem_wr_o)
    else $error("port access past byte total");
  a_write_cause: assert property (mem_wr_o |-> $past(wr_i && addr_i == 8'hC5 && port_go))
    else $error("memory write without port write");
  a_step_two: assert property (port_go ##1 port_go |=> mem_addr_o == $past(mem_addr_o) + 2)
    else $error("pointer did not step by two");
  a_soft_reset: assert property (wr_i && addr_i == 8'hA9 && wdata_i[15:0] == 16'h00F6
    |-> ##2 en == 4'h0 && port_done_o)
    else $error("soft reset did not clear");
  a_window_arms: assert property (wr_i && addr_i == 8'hB2 && wdata_i[31:16] != 0 |-> ##[1:3] !port_done_o)
    else $error("window load left port done");
  c_burst: cover property (mem_rd_o ##1 mem_rd_o);
  c_write: cover property (mem_wr_o);
  c_done: cover property ($rose(port_done_o));
endmodule // hc_buffer_ram_control_sva
bind hc_buffer_ram_control hc_buffer_ram_control_sva #(.AW(AW)) hc_buffer_ram_control_sva_inst (.clk_i, .rst_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .async_en_o, .periodic_en_o, .iso_a_en_o, .iso_b_en_o, .mem_wr_o,
  .mem_rd_o, .mem_addr_o, .port_done_o);
`default_nettype wire

// >>> host_cpu.sv
// Host driver model: register bus master noting expected read data
`timescale 1ns/1ps
`default_nettype none
module host_cpu (
  input  wire logic        clk_i,           // clock
  output var  logic [7:0]  addr_o = 8'h00,  // command code
  output var  logic [31:0] wdata_o = 32'h0, // write data
  output var  logic        wr_o = 1'b0,     // write strobe
  output var  logic        rd_o = 1'b0      // read strobe
);
  logic [31:0] exp_q[$];
  // Strobes are left up until the next call so no step drives one twice
  task automatic op(input logic we, input logic [7:0] c, input logic [31:0] d);
    if (!we)
      exp_q.push_back(d);
    addr_o <= c;
    wdata_o <= d;
    wr_o <= we;
    rd_o <= !we;
    @(posedge clk_i);
  endtask
  task automatic rest;
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule // host_cpu
`default_nettype wire

// >>> hc_buffer_ram_control_bench.sv
// Self-checking bench for the buffer RAM control block
`timescale 1ns/1ps
`default_nettype none
module hc_buffer_ram_control_bench;
  logic clk_i, rst_i, wr_i, rd_i, mem_wr_o, mem_rd_o, port_done_o, async_en_o, periodic_en_o, iso_a_en_o, iso_b_en_o;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, w, mq[$], rq[$];
  logic [15:0] mem_rdata_i, mem_wdata_o;
  logic [14:0] mem_addr_o;
  logic [4:0]  ev;
  logic [1:0]  busy;
  logic        rd_seen = 1'b0;
  int          errors = 0, checked = 0, cycles = 0, seed = 19, i;
  host_cpu host_cpu_inst (.clk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
  hc_buffer_ram_control hc_buffer_ram_control_inst (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .half_toggle_i(ev[0]), .iso_a_read_i(ev[1]), .iso_b_read_i(ev[2]), .iso_a_refill_i(ev[3]),
    .iso_b_refill_i(ev[4]), .iso_a_busy_i(busy[0]), .iso_b_busy_i(busy[1]), .async_en_o, .periodic_en_o,
    .iso_a_en_o, .iso_b_en_o, .mem_wr_o, .mem_rd_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .port_done_o);
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task end_of_test;
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task wr(input logic [7:0] c, input logic [31:0] d);
    host_cpu_inst.op(1'b1, c, d);
  endtask
  task rd(input logic [7:0] c, input logic [31:0] e);
    host_cpu_inst.op(1'b0, c, e);
  endtask
  task idle(input logic [4:0] v);
    ev <= v;
    host_cpu_inst.rest();
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    rd_seen <= rd_i && !rst_i;
    cycles <= cycles + 1;
    if (rd_seen)
      check(rdata_o, host_cpu_inst.exp_q.pop_front());
    if (mem_wr_o === 1'b1)
      check({1'b0, mem_addr_o, mem_wdata_o}, mq.pop_front());
    if (mem_rd_o === 1'b1)
      check({17'h0_0000, mem_addr_o}, rq.pop_front());
    if (cycles == 2000)
    begin
      errors++;
      end_of_test();
    end
  end
  initial
  begin
    rst_i = 1'b1;
    ev = 5'h00;
    busy = 2'b00;
    mem_rdata_i = 16'h0000;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h2C, 0);
    rd(8'h32, 0);
    rd(8'h45, 0);
    rd(8'h27, 0);
    for (i = 0; i < 8; i++)
    begin
      w = $random(seed);
      wr(8'hAC, w);
      rd(8'h2C, {27'h0, w[4:0]});
      check({28'h000_0000, async_en_o, periodic_en_o, iso_b_en_o, iso_a_en_o}, {28'h000_0000, w[3:0]});
    end
    wr(8'hB2, 32'hFFFF_FFFF);
    rd(8'h32, 32'hFFFF_7FFF);
    wr(8'hB2, 32'h0005_0010);
    for (i = 0; i < 3; i++)
    begin
      w = $random(seed);
      mem_rdata_i <= w[15:0];
      rq.push_back(32'h0000_0010 + 32'(2 * i));
      rd(8'h45, {16'h0000, w[15:0]});
    end
    idle(0);
    idle(0);
    check({31'h0000_0000, port_done_o}, 32'h0000_0001);
    // Odd total is spent; a changed memory word proves no fetch
    mem_rdata_i <= ~w[15:0];
    rd(8'h45, {16'h0000, w[15:0]});
    wr(8'hB2, 32'h0004_0020);
    for (i = 0; i < 2; i++)
    begin
      w = $random(seed);
      mq.push_back({1'b0, 15'h0020 + 15'(2 * i), w[15:0]});
      wr(8'hC5, w);
    end
    idle(0);
    idle(0);
    wr(8'hC5, w);
    wr(8'hAC, 32'h8);
    idle(5'h01);
    idle(0);
    rd(8'h2C, 32'h408);
    wr(8'hAC, 32'h18);
    rd(8'h2C, 32'h418);
    wr(8'hAC, 0);
    wr(8'hAC, 32'h10);
    rd(8'h2C, 32'h10);
    idle(5'h06);
    idle(0);
    rd(8'h2C, 32'h310);
    busy <= 2'b11;
    idle(5'h18);
    idle(0);
    rd(8'h2C, 32'h70);
    wr(8'hA9, 32'hF7);
    rd(8'h2C, 32'h70);
    busy <= 2'b00;
    wr(8'hA9, 32'hF6);
    idle(0);
    idle(0);
    rd(8'h2C, 0);
    rd(8'h32, 0);
    idle(0);
    idle(0);
    check(32'(mq.size()), 0);
    check(32'(rq.size()), 0);
    check(32'(host_cpu_inst.exp_q.size()), 0);
    end_of_test();
  end
endmodule // hc_buffer_ram_control_bench
`default_nettype wire
